// ==== verilog/twd_timer_wdog.sv ====
// Top of the timing watchdog: prescaler, periodic timer, watchdog and registers.
`timescale 1ns/1ns
`include "twd_cfg.svh"
module twd_timer_wdog (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow_clock_in,
	input wire twd_pkg::twd_mode_t power_mode,
	input wire logic [2:0] reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic periodic_tick_irq,
	output logic timer_zero_pulse,
	output logic wdog_running,
	output logic device_reset_req
);
	// -------------------------------------------------------------
	// Functions
	// -------------------------------------------------------------

	// Lock state of the register at a select, from the config bits.
	function automatic logic sel_locked(input logic [2:0] sel, input logic [5:0] cfg);
		case (sel)
			`TWD_SEL_CFG: sel_locked = cfg[`TWD_CFG_LOCK_CFG];
			`TWD_SEL_PRESC: sel_locked = cfg[`TWD_CFG_LOCK_PRESC];
			`TWD_SEL_RELOAD: sel_locked = cfg[`TWD_CFG_LOCK_TMR];
			`TWD_SEL_CTRL: sel_locked = cfg[`TWD_CFG_LOCK_TMR];
			`TWD_SEL_WDOG_COUNT_VALUE: sel_locked = cfg[`TWD_CFG_LOCK_WDC];
			default: sel_locked = 1'b0;
		endcase
	endfunction

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	logic [5:0] cfg_q; // Locks, watchdog clock select, key enable.
	logic [2:0] presc_q; // Prescale code.
	logic [15:0] reload_q; // Timer reload value.
	logic [15:0] tmr_cnt_q; // Timer count.
	logic restart_q; // Pending restart request.
	logic tflag_q; // Terminal count flag.
	logic tie_q; // Tick interrupt enable.
	logic zero_pulse_q; // Terminal pulse, one tick long.
	logic irq_q; // Interrupt pulse.
	logic [7:0] wdog_count_value_q; // Stored watchdog count value.
	logic [15:0] rdata_q; // Read data.
	logic run; // Not halted.
	logic acc_ok; // Register reachable in this power mode.
	logic wr; // Accepted write.
	logic rd; // Accepted read.
	logic tick; // Prescaled tick, one clock.
	logic zero_rise; // Timer reaches zero at this tick.
	logic wdog_tick; // Selected watchdog clock edge.
	logic cnt_wr; // Write to the watchdog count register.
	logic key_wr; // Write to the key register.
	logic key_good; // Key data matches.
	logic key_en; // Key servicing selected.
	logic wd_running; // Watchdog started.
	logic wd_load; // Reload the watchdog counter.
	logic [7:0] wd_value; // Value for that reload.
	logic wd_bad; // Wrong key while key servicing.
	logic wd_err; // Watchdog error from the core.

	// -------------------------------------------------------------
	// Access gating
	// -------------------------------------------------------------

	assign run = (power_mode != twd_pkg::TWD_HALT);
	assign acc_ok = (power_mode == twd_pkg::TWD_ACTIVE) || (reg_sel == `TWD_SEL_KEY);
	assign wr = reg_wr && run && acc_ok && !sel_locked(reg_sel, cfg_q);
	assign rd = reg_rd && run && acc_ok;

	assign reg_rdata = rdata_q;
	assign periodic_tick_irq = irq_q;
	assign timer_zero_pulse = zero_pulse_q;
	assign wdog_running = wd_running;
	assign device_reset_req = wd_err;

	// -------------------------------------------------------------
	// Prescaler
	// -------------------------------------------------------------
	twd_prescaler u_presc (
		.clk(clk),
		.rst(rst),
		.run(run),
		.slow_clock_in(slow_clock_in),
		.div_code(presc_q),
		.prescaled_tick(tick)
	);

	// -------------------------------------------------------------
	// Configuration registers
	// -------------------------------------------------------------

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= `TWD_CFG_RST;
		end else if (wr && reg_sel == `TWD_SEL_CFG) begin
			cfg_q <= cfg_q | reg_wdata[5:0];
		end
	end

	// Prescale code; a reserved code behaves as divide by 32.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_q <= `TWD_PRESC_RST;
		end else if (wr && reg_sel == `TWD_SEL_PRESC) begin
			presc_q <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reload_q <= `TWD_RELOAD_RST;
		end else if (wr && reg_sel == `TWD_SEL_RELOAD) begin
			reload_q <= reg_wdata;
		end
	end

	// Interrupt enable of the control register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tie_q <= 1'b0;
		end else if (wr && reg_sel == `TWD_SEL_CTRL) begin
			tie_q <= reg_wdata[`TWD_CTRL_TIE];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restart_q <= 1'b0;
		end else if (wr && reg_sel == `TWD_SEL_CTRL && reg_wdata[`TWD_CTRL_RESTART]) begin
			restart_q <= 1'b1;
		end else if (run && tick) begin
			restart_q <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Periodic timer
	// -------------------------------------------------------------

	// A restart tick is excluded through restart_q, so no pulse can come from it.
	assign zero_rise = run && tick && !restart_q && tmr_cnt_q == 16'h0001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr_cnt_q <= `TWD_RELOAD_RST;
		end else if (run && tick) begin
			if (restart_q || tmr_cnt_q == 16'h0000) begin
				tmr_cnt_q <= reload_q;
			end else begin
				tmr_cnt_q <= tmr_cnt_q - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zero_pulse_q <= 1'b0;
		end else if (run && tick) begin
			zero_pulse_q <= zero_rise;
		end
	end

	// flag set wins over read clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tflag_q <= 1'b0;
		end else if (zero_rise) begin
			tflag_q <= 1'b1;
		end else if (rd && reg_sel == `TWD_SEL_CTRL && !cfg_q[`TWD_CFG_LOCK_TMR]) begin
			tflag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= zero_rise && tie_q;
		end
	end

	// -------------------------------------------------------------
	// Register read
	// -------------------------------------------------------------

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (rd) begin
			if (sel_locked(reg_sel, cfg_q)) begin
				rdata_q <= `TWD_LOCKED_RD;
			end else begin
				case (reg_sel)
					`TWD_SEL_CFG: rdata_q <= {10'h000, cfg_q};
					`TWD_SEL_PRESC: rdata_q <= {13'h0000, presc_q};
					`TWD_SEL_RELOAD: rdata_q <= reload_q;
					`TWD_SEL_CTRL: rdata_q <= {13'h0000, tie_q, tflag_q, restart_q};
					default: rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Watchdog
	// -------------------------------------------------------------
	assign key_en = cfg_q[`TWD_CFG_KEY_EN];
	assign cnt_wr = wr && reg_sel == `TWD_SEL_WDOG_COUNT_VALUE;
	assign key_wr = wr && reg_sel == `TWD_SEL_KEY;
	assign key_good = reg_wdata[7:0] == `TWD_KEY_VALUE;
	assign wdog_tick = cfg_q[`TWD_CFG_WCLK_SEL] ? (run && tick) : zero_rise;
	assign wd_bad = key_wr && key_en && !key_good;
	assign wd_load = (cnt_wr && (!key_en || !wd_running))
		|| (key_wr && ((key_en && key_good) || !wd_running));
	assign wd_value = cnt_wr ? reg_wdata[7:0] : wdog_count_value_q;

	// Stored count value, write-only to software.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdog_count_value_q <= `TWD_WDOG_COUNT_VALUE_RST;
		end else if (cnt_wr) begin
			wdog_count_value_q <= reg_wdata[7:0];
		end
	end

	twd_wdog_core u_wdog (
		.clk(clk),
		.rst(rst),
		.run(run),
		.wdog_tick(wdog_tick),
		.start(cnt_wr || key_wr),
		.load(wd_load),
		.load_value(wd_value),
		.bad_key(wd_bad),
		.running(wd_running),
		.wdog_error(wd_err)
	);

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	property p_decrement;
		@(posedge clk) disable iff (rst)
		run && tick && !restart_q && tmr_cnt_q != 16'h0000 |=> tmr_cnt_q == $past(tmr_cnt_q) - 16'h0001;
	endproperty
	a_decrement: assert property (p_decrement) else $error("timer did not decrement");

	property p_reload;
		@(posedge clk) disable iff (rst)
		run && tick && !restart_q && tmr_cnt_q == 16'h0000 |=> tmr_cnt_q == $past(reload_q);
	endproperty
	a_reload: assert property (p_reload) else $error("timer did not reload at zero");

	property p_restart;
		@(posedge clk) disable iff (rst)
		run && tick && restart_q && !(wr && reg_sel == `TWD_SEL_CTRL)
		|=> !restart_q && tmr_cnt_q == $past(reload_q);
	endproperty
	a_restart: assert property (p_restart) else $error("restart not taken or not cleared");

	property p_pulse;
		@(posedge clk) disable iff (rst)
		zero_rise |=> zero_pulse_q && tflag_q;
	endproperty
	a_pulse: assert property (p_pulse) else $error("no terminal pulse or flag");

	property p_irq;
		@(posedge clk) disable iff (rst)
		zero_rise |=> irq_q == $past(tie_q);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not gated by enable");

	property p_halt;
		@(posedge clk) disable iff (rst)
		!run |=> $stable(tmr_cnt_q) && $stable(cfg_q) && $stable(reload_q);
	endproperty
	a_halt: assert property (p_halt) else $error("state moved in halt");

	property p_lock;
		@(posedge clk) disable iff (rst)
		cfg_q[`TWD_CFG_LOCK_CFG] |=> $stable(cfg_q) ##1 $stable(cfg_q);
	endproperty
	a_lock: assert property (p_lock) else $error("locked config changed");

	property p_mode;
		@(posedge clk) disable iff (rst)
		reg_wr && power_mode != twd_pkg::TWD_ACTIVE && reg_sel != `TWD_SEL_KEY
		|=> $stable(reload_q) && $stable(presc_q) && $stable(wdog_count_value_q);
	endproperty
	a_mode: assert property (p_mode) else $error("write taken outside active mode");

	property p_err_hold;
		@(posedge clk) disable iff (rst)
		wd_err |=> wd_err && device_reset_req;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("device reset request dropped");

	property p_idle;
		@(posedge clk) disable iff (rst)
		!wd_running && !$past(wd_running) |-> !wd_err;
	endproperty
	a_idle: assert property (p_idle) else $error("error from an idle watchdog");

	c_irq: cover property (@(posedge clk) disable iff (rst) irq_q);
	c_restart: cover property (@(posedge clk) disable iff (rst) run && tick && restart_q);
	c_err: cover property (@(posedge clk) disable iff (rst) $rose(wd_err));
	c_key: cover property (@(posedge clk) disable iff (rst) key_wr && key_en && key_good && wd_running);
endmodule

// ==== verilog/twd_cfg.svh ====
// Register selects, field positions and reset values of the timing watchdog.
`ifndef TWD_CFG_SVH
`define TWD_CFG_SVH
// -------------------------------------------------------------
// Register selects
// -------------------------------------------------------------
`define TWD_SEL_CFG 3'h0
`define TWD_SEL_PRESC 3'h1
`define TWD_SEL_RELOAD 3'h2
`define TWD_SEL_CTRL 3'h3
`define TWD_SEL_WDOG_COUNT_VALUE 3'h4
`define TWD_SEL_KEY 3'h5
// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define TWD_CFG_LOCK_CFG 0
`define TWD_CFG_LOCK_PRESC 1
`define TWD_CFG_LOCK_TMR 2
`define TWD_CFG_LOCK_WDC 3
`define TWD_CFG_WCLK_SEL 4
`define TWD_CFG_KEY_EN 5
`define TWD_CTRL_RESTART 0
`define TWD_CTRL_TFLAG 1
`define TWD_CTRL_TIE 2
// -------------------------------------------------------------
// Reset values and constants
// -------------------------------------------------------------
`define TWD_CFG_RST 6'h00
`define TWD_PRESC_RST 3'h0
`define TWD_RELOAD_RST 16'hFFFF
`define TWD_WDOG_COUNT_VALUE_RST 8'h0F
`define TWD_KEY_VALUE 8'h5C
`define TWD_LOCKED_RD 16'h0000
`endif

// ==== verilog/twd_pkg.sv ====
// Types and the shared prescale decode function of the timing watchdog.
package twd_pkg;
	// Power mode of the surrounding device.
	typedef enum logic [1:0] {
		TWD_ACTIVE,
		TWD_SAVE,
		TWD_IDLE,
		TWD_HALT
	} twd_mode_t;

	// Terminal value of the prescale counter; reserved codes divide by 32.
	function automatic logic [4:0] twd_presc_limit(input logic [2:0] code);
		twd_presc_limit = (code > 3'h5) ? 5'h1f : 5'((6'h01 << code) - 6'h01);
	endfunction
endpackage

// ==== verilog/twd_prescaler.sv ====
// Slow clock prescaler that forms the one-cycle prescaled tick.
`timescale 1ns/1ns
module twd_prescaler (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic slow_clock_in,
	input wire logic [2:0] div_code,
	output logic prescaled_tick
);
	// -------------------------------------------------------------
	// Slow clock edge and divider
	// -------------------------------------------------------------
	logic slow_prev_q; // Last sampled slow clock level.
	logic [4:0] div_q; // Slow edges seen in this tick period.
	logic tick_q; // One-cycle tick.
	logic slow_rise;

	assign slow_rise = slow_clock_in && !slow_prev_q;
	assign prescaled_tick = tick_q;

	// The edge history freezes in halt so no false edge appears on resume.
	// It resets high, so a slow clock that is already high at release is not counted as an edge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_prev_q <= 1'b1;
		end else if (run) begin
			slow_prev_q <= slow_clock_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= 5'h00;
			tick_q <= 1'b0;
		end else if (run) begin
			// A tick raised just before halt is held, so the timer takes it on resume.
			tick_q <= 1'b0;
			if (slow_rise) begin
				if (div_q >= twd_pkg::twd_presc_limit(div_code)) begin
					div_q <= 5'h00;
					tick_q <= 1'b1;
				end else begin
					div_q <= div_q + 5'h01;
				end
			end
		end
	end
endmodule

// ==== verilog/twd_wdog_core.sv ====
// Eight-bit watchdog counter with late, early and bad-key error detection.
`timescale 1ns/1ns
`include "twd_cfg.svh"
module twd_wdog_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic wdog_tick,
	input wire logic start,
	input wire logic load,
	input wire logic [7:0] load_value,
	input wire logic bad_key,
	output logic running,
	output logic wdog_error
);
	logic run_q; // Watchdog has been started.
	logic [7:0] cnt_q; // Watchdog down counter.
	logic seen_q; // A service already fell in this watchdog clock cycle.
	logic err_q; // Sticky error, cleared only by reset.

	assign running = run_q;
	assign wdog_error = err_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
		end else if (run && start) begin
			run_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= `TWD_WDOG_COUNT_VALUE_RST;
		end else if (run && load) begin
			cnt_q <= load_value;
		end else if (run && run_q && wdog_tick && cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// one service per clock
	// A service in the same cycle as a tick opens the new cycle, so set wins.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_q <= 1'b0;
		end else if (run && load) begin
			seen_q <= 1'b1;
		end else if (run && wdog_tick) begin
			seen_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (run) begin
			if (run_q && wdog_tick && cnt_q == 8'h00 && !load) begin
				err_q <= 1'b1;
			end
			if (bad_key || (load && run_q && seen_q)) begin
				err_q <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	property p_late_err;
		@(posedge clk) disable iff (rst)
		run && run_q && wdog_tick && cnt_q == 8'h00 && !load |=> err_q;
	endproperty
	a_late_err: assert property (p_late_err) else $error("late service gave no error");

	property p_bad_key;
		@(posedge clk) disable iff (rst)
		run && bad_key |=> err_q;
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("bad key gave no error");

	property p_twice;
		@(posedge clk) disable iff (rst)
		run && load && run_q && seen_q |=> err_q;
	endproperty
	a_twice: assert property (p_twice) else $error("double service gave no error");
endmodule

// ==== tb/twd_tb.sv ====
// Self-checking bench of the timing watchdog top module.
`timescale 1ns/1ns
`include "twd_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	// ------------------------------------------------------------
	// Signals, counters and the table of plain register cases
	// ------------------------------------------------------------
	logic clk;
	logic rst;
	logic slow_clock_in;
	twd_pkg::twd_mode_t power_mode;
	logic [2:0] reg_sel;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic periodic_tick_irq;
	logic timer_zero_pulse;
	logic wdog_running;
	logic device_reset_req;
	int failures; // Mismatches seen.
	int checked; // Comparisons made.
	int cycles; // Clock cycles since time zero, for the hang guard.
	int irqs; // Interrupt pulses seen while waiting for the timer.
	int n; // Cycles counted by the waiting tasks.
	int w; // Scratch cycle count.
	logic [1:0] slow_q; // Slow clock phase; one slow period is four clk cycles.
	logic [15:0] v; // Last value read back.
	// One row: register, whether it is written first, data, expected read-back.
	typedef struct {logic [2:0] sel; logic w; logic [15:0] d; logic [15:0] e;} twd_row_t;
	twd_row_t rows [12];

	twd_timer_wdog dut (
		.clk(clk),
		.rst(rst),
		.slow_clock_in(slow_clock_in),
		.power_mode(power_mode),
		.reg_sel(reg_sel),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.periodic_tick_irq(periodic_tick_irq),
		.timer_zero_pulse(timer_zero_pulse),
		.wdog_running(wdog_running),
		.device_reset_req(device_reset_req)
	);

	// ------------------------------------------------------------
	// Clocks, hang guard and shared tasks
	// ------------------------------------------------------------
	// The system clock runs at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// The slow clock moves just after the edge, so the design sees clean levels.
	always @(posedge clk) begin
		#1;
		slow_q = slow_q + 2'd1;
		slow_clock_in = slow_q[1];
	end

	// A hang counts as a mismatch and ends the run through the same report.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			summarize();
		end
	end

	// Prints the counts and the verdict, then stops.
	task summarize();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Lets k edges pass; inputs always change 1 ns after an edge, and idle strobes drop here.
	task step(input int k);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (k) begin
			@(posedge clk);
			#1;
		end
	endtask

	// Write strobe; it stays up so back-to-back writes never assign it twice in one time step.
	task wr(input logic [2:0] s, input logic [15:0] d);
		reg_sel = s;
		reg_wdata = d;
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
	endtask

	// Read strobe; the data is registered at the taking edge and picked up 1 ns later.
	task rd(input logic [2:0] s);
		reg_sel = s;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		v = reg_rdata;
	endtask

	// Counts edges up to the next rise of the zero pulse, and interrupt pulses meanwhile.
	task next_rise();
		n = 0;
		while (timer_zero_pulse === 1'b1 && n < 5000) begin
			step(1);
			n++;
			if (periodic_tick_irq === 1'b1) irqs++;
		end
		while (timer_zero_pulse !== 1'b1 && n < 5000) begin
			step(1);
			n++;
			if (periodic_tick_irq === 1'b1) irqs++;
		end
	endtask

	// Counts edges until the reset request shows, at most lim.
	task wait_req(input int lim);
		n = 0;
		while (device_reset_req !== 1'b1 && n < lim) begin
			step(1);
			n++;
		end
	endtask

	// Four cycles of reset, then the reset values of every output.
	task do_reset();
		rst = 1'b1;
		power_mode = twd_pkg::TWD_ACTIVE;
		step(4);
		rst = 1'b0;
		`CHK(reg_rdata, 16'h0000)
		`CHK(periodic_tick_irq, 1'b0)
		`CHK(timer_zero_pulse, 1'b0)
		`CHK(wdog_running, 1'b0)
		`CHK(device_reset_req, 1'b0)
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		slow_q = 2'd0;
		slow_clock_in = 1'b0;
		reg_sel = 3'h0;
		reg_wdata = 16'h0000;
		rows = '{
			'{`TWD_SEL_RELOAD, 1'b0, 16'h0000, 16'hFFFF},
			'{`TWD_SEL_PRESC, 1'b0, 16'h0000, 16'h0000},
			'{`TWD_SEL_CFG, 1'b0, 16'h0000, 16'h0000},
			'{`TWD_SEL_CTRL, 1'b0, 16'h0000, 16'h0000},
			'{`TWD_SEL_WDOG_COUNT_VALUE, 1'b0, 16'h0000, 16'h0000},
			'{`TWD_SEL_PRESC, 1'b1, 16'h0005, 16'h0005},
			'{`TWD_SEL_PRESC, 1'b1, 16'h00FF, 16'h0007},
			'{`TWD_SEL_RELOAD, 1'b1, 16'h0001, 16'h0001},
			'{`TWD_SEL_RELOAD, 1'b1, 16'hA5C3, 16'hA5C3},
			'{`TWD_SEL_CFG, 1'b1, 16'h0010, 16'h0010},
			'{`TWD_SEL_CFG, 1'b1, 16'h0000, 16'h0010},
			'{3'h6, 1'b1, 16'h1234, 16'h0000}};
		do_reset();
		// An untouched watchdog stays silent.
		step(100);
		`CHK(device_reset_req, 1'b0)
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].sel, rows[i].d);
			rd(rows[i].sel);
			`CHK(v, rows[i].e)
		end
		$display("register table done");
		// Period for prescale codes 0 to 5 and pulse width at code 5; restart realigns the count.
		do_reset();
		wr(`TWD_SEL_RELOAD, 16'h0002);
		for (int p = 0; p < 6; p++) begin
			wr(`TWD_SEL_PRESC, 16'(p));
			wr(`TWD_SEL_CTRL, 16'h0005);
			next_rise();
			wr(`TWD_SEL_CTRL, 16'h0004);
			next_rise();
			irqs = 0;
			next_rise();
			`CHK(n, 12 << p)
			`CHK(irqs, 1)
		end
		w = 0;
		while (timer_zero_pulse === 1'b1 && w < 500) begin
			step(1);
			w++;
		end
		`CHK(w, 128)
		rd(`TWD_SEL_CTRL);
		`CHK(v, 16'h0006)
		rd(`TWD_SEL_CTRL);
		`CHK(v, 16'h0004)
		wr(`TWD_SEL_CTRL, 16'h0002);
		rd(`TWD_SEL_CTRL);
		`CHK(v, 16'h0000)
		wr(`TWD_SEL_PRESC, 16'h0000);
		next_rise();
		irqs = 0;
		next_rise();
		`CHK(irqs, 0)
		$display("timer periods done");
		// A reload written mid-count waits for the next zero.
		wr(`TWD_SEL_PRESC, 16'h0001);
		next_rise();
		next_rise();
		step(10);
		wr(`TWD_SEL_RELOAD, 16'h0005);
		next_rise();
		`CHK(n, 13)
		next_rise();
		`CHK(n, 48)
		$display("reload timing done");
		// Halt for a whole number of slow periods, then resume in place.
		wr(`TWD_SEL_RELOAD, 16'h0002);
		wr(`TWD_SEL_PRESC, 16'h0000);
		next_rise();
		next_rise();
		step(5);
		power_mode = twd_pkg::TWD_HALT;
		w = 0;
		repeat (100) begin
			step(1);
			if (timer_zero_pulse !== 1'b0) w++;
		end
		`CHK(w, 0)
		power_mode = twd_pkg::TWD_ACTIVE;
		next_rise();
		`CHK(n, 7)
		$display("halt done");
		// Power save: timer runs, reload write refused; in idle a key write starts the watchdog.
		// no recent restart or service
		power_mode = twd_pkg::TWD_SAVE;
		wr(`TWD_SEL_RELOAD, 16'h0009);
		next_rise();
		next_rise();
		`CHK(n, 12)
		power_mode = twd_pkg::TWD_IDLE;
		wr(`TWD_SEL_KEY, 16'h0000);
		step(1);
		`CHK(wdog_running, 1'b1)
		wait_req(300);
		`CHK((n >= 170 && n <= 200), 1'b1)
		$display("power save done");
		// Tick clock, count-register service, then late service.
		do_reset();
		wr(`TWD_SEL_CFG, 16'h0010);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0003);
		step(1);
		`CHK(wdog_running, 1'b1)
		repeat (4) begin
			step(8);
			wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0003);
		end
		`CHK(device_reset_req, 1'b0)
		wait_req(40);
		`CHK((n >= 12 && n <= 18), 1'b1)
		step(20);
		`CHK(device_reset_req, 1'b1)
		`CHK(wdog_running, 1'b1)
		// Two count-register services within one watchdog clock.
		do_reset();
		wr(`TWD_SEL_CFG, 16'h0010);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0040);
		step(6);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0040);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0040);
		wait_req(6);
		`CHK(device_reset_req, 1'b1)
		$display("count service done");
		// Key service keeps it alive, a wrong key trips it.
		do_reset();
		wr(`TWD_SEL_CFG, 16'h0030);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0003);
		repeat (3) begin
			step(8);
			wr(`TWD_SEL_KEY, 16'h005C);
		end
		`CHK(device_reset_req, 1'b0)
		step(8);
		wr(`TWD_SEL_KEY, 16'h005B);
		wait_req(4);
		`CHK(device_reset_req, 1'b1)
		// Two good keys within one watchdog clock.
		do_reset();
		wr(`TWD_SEL_CFG, 16'h0030);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0003);
		step(6);
		wr(`TWD_SEL_KEY, 16'h005C);
		wr(`TWD_SEL_KEY, 16'h005C);
		wait_req(4);
		`CHK(device_reset_req, 1'b1)
		$display("key service done");
		// Locks refuse writes, read as zero and last until reset.
		do_reset();
		wr(`TWD_SEL_CFG, 16'h0004);
		wr(`TWD_SEL_RELOAD, 16'h0007);
		rd(`TWD_SEL_RELOAD);
		`CHK(v, 16'h0000)
		wr(`TWD_SEL_CFG, 16'h0008);
		wr(`TWD_SEL_WDOG_COUNT_VALUE, 16'h0003);
		step(2);
		`CHK(wdog_running, 1'b0)
		wr(`TWD_SEL_CFG, 16'h0001);
		wr(`TWD_SEL_CFG, 16'h0000);
		rd(`TWD_SEL_CFG);
		`CHK(v, 16'h0000)
		do_reset();
		rd(`TWD_SEL_RELOAD);
		`CHK(v, 16'hFFFF)
		$display("locks done");
		summarize();
	end
endmodule
